// *** crp_battery_model.sv ***
// battery terminal model seen by the charge regulation block
// assumes the bench sets the rest level; the terminal follows one clock later
`timescale 1ns/1ps
`default_nettype none
module crp_battery_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] levelReq,
  output var  logic [15:0] batteryVoltage
);
  // terminal voltage settles to the requested level
  always_ff @(posedge core_clk) begin
    batteryVoltage <= levelReq;
  end
endmodule
`default_nettype wire

// *** crp_charge_regulation.sv ***
// charge regulation block: preset selector, hysteresis charge switch, stage timers
// assumes an AXI4-Lite master, synchronous measurement inputs and external nv storage
`timescale 1ns/1ps
`default_nettype none
module crp_charge_regulation #(
  parameter int unsigned SEC_CYC = crp_pkg::SEC_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // measurements
  input  wire logic [15:0] batteryVoltage,   // 10 mV units
  input  wire logic [7:0]  chargeCurrent,    // 0.1 A units
  input  wire logic        nightTime,
  // lockout non-volatile storage
  input  wire logic        nvLockoutIn,
  output logic             nvLockoutWrite,
  output logic             nvLockoutData,
  // power terminals
  output logic             chargeSwitchOn,
  output logic             loadOutputOn
);
  import crp_pkg::*;

  if (SEC_CYC < 2) $error("SEC_CYC must be at least 2");

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  function automatic crp_settings_t presetFor(input logic [2:0] prog);
    crp_settings_t s;
    logic          sealed;
    sealed = prog[0];
    s.floatSetpoint      = PV_FLOAT;
    s.absorptionSetpoint = PV_ABSORB;
    s.boostVoltageLimit  = sealed ? PV_BOOST_SEAL : PV_BOOST_FLOOD;
    s.equaliseVoltage    = sealed ? PV_EQ_SEAL : PV_EQ_FLOOD;
    s.hysteresisBand     = PV_BAND;
    s.boostReturn        = PV_RETURN;
    s.absorptionDuration = PT_ABSORB;
    s.equaliseDuration   = sealed ? PT_EQ_SEAL : PT_EQ_FLOOD;
    s.boostDuration      = PT_BOOST;
    s.chargeCurrentLimit = PC_LIMIT;
    // night lighting on programs 2 and 3
    s.nightLight         = prog[1];
    s.lowBattDisconnect  = 1'b1;
    return s;
  endfunction

  // scale a 12 V set point by system volts / 12
  function automatic logic [18:0] scaleV(input logic [15:0] v, input logic [2:0] m);
    return 19'(v) * 19'(m);
  endfunction

  // register state
  logic [2:0]    progSel_q;
  logic [2:0]    voltMult_q;
  logic          pwmSel_q;
  logic          lockout_q;
  logic          nvCaptured_q;
  logic          nvWrite_q;
  crp_settings_t custom_q;
  crp_settings_t active;
  logic          customMode;
  logic [2:0]    multEff;

  // program 4 runs on the adjustable set
  assign customMode = (progSel_q == PROG_CUSTOM);
  assign active     = customMode ? custom_q : presetFor(progSel_q);
  assign multEff    = (voltMult_q == 3'h0) ? 3'h1 : voltMult_q;

  // write channel holding
  logic        awHeld_q;
  logic        wHeld_q;
  logic [7:0]  wAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        doWrite;

  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready  = !wHeld_q;
  assign doWrite       = awHeld_q && wHeld_q && !s_axi_bvalid;

  // capture address and data in either order
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      wAddr_q  <= 8'h00;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !awHeld_q) begin
        awHeld_q <= 1'b1;
        wAddr_q  <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_q) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // decode and classify a write
  logic wrCtrl;
  logic wrLock;
  logic wrCustom;
  logic wrMapped;
  logic [31:0] wMask;
  always_comb begin
    wrCtrl   = 1'b0;
    wrLock   = 1'b0;
    wrCustom = 1'b0;
    wrMapped = 1'b1;
    if (wAddr_q[7:2] == OFS_CTRL[7:2]) begin
      wrCtrl = 1'b1;
    end else if (wAddr_q[7:2] == OFS_LOCK[7:2]) begin
      wrLock = 1'b1;
    end else if (wAddr_q[7:2] >= OFS_VSET1[7:2] && wAddr_q[7:2] <= OFS_LOAD[7:2]) begin
      wrCustom = 1'b1;
    end else if (wAddr_q[7:2] == OFS_STATUS[7:2] || wAddr_q[7:2] == OFS_MEAS[7:2]) begin
      wrMapped = 1'b1;   // read-only, write ignored
    end else begin
      wrMapped = 1'b0;
    end
  end
  assign wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

  logic ctrlOk;
  logic customOk;
  assign ctrlOk   = wrCtrl && !lockout_q;
  assign customOk = wrCustom && !lockout_q && customMode;

  // write response
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      if (!wrMapped) begin
        s_axi_bresp <= RESP_DECERR;
      end else if ((wrCtrl && !ctrlOk) || (wrCustom && !customOk)) begin
        s_axi_bresp <= RESP_SLVERR;
      end else begin
        s_axi_bresp <= RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      progSel_q  <= RST_PROG;
      voltMult_q <= RST_MULT;
      pwmSel_q   <= RST_PWM;
    end else if (doWrite && ctrlOk && wStrb_q[0]) begin
      if (wData_q[CTRL_PROG_LSB +: 3] <= PROG_CUSTOM) begin
        progSel_q <= wData_q[CTRL_PROG_LSB +: 3];
      end
      voltMult_q <= wData_q[CTRL_MULT_LSB +: 3];
      pwmSel_q   <= wData_q[CTRL_PWM_BIT];
    end
  end

  // lockout restored from and saved to nv storage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lockout_q    <= 1'b0;
      nvCaptured_q <= 1'b0;
      nvWrite_q    <= 1'b0;
    end else begin
      nvWrite_q <= 1'b0;
      if (!nvCaptured_q) begin
        nvCaptured_q <= 1'b1;
        lockout_q    <= nvLockoutIn;
      end else if (doWrite && wrLock && wStrb_q[0] && wData_q[0]) begin
        lockout_q <= !lockout_q;   // toggle, always allowed
        nvWrite_q <= 1'b1;
      end
    end
  end
  assign nvLockoutWrite = nvWrite_q;
  assign nvLockoutData  = lockout_q;

  // adjustable set, starts as the sealed preset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      custom_q <= presetFor(RST_PROG);
    end else if (doWrite && customOk) begin
      if (wAddr_q[7:2] == OFS_VSET1[7:2]) begin
        custom_q.floatSetpoint      <= (custom_q.floatSetpoint & ~wMask[15:0])
                                     | (wData_q[15:0] & wMask[15:0]);
        custom_q.absorptionSetpoint <= (custom_q.absorptionSetpoint & ~wMask[31:16])
                                     | (wData_q[31:16] & wMask[31:16]);
      end else if (wAddr_q[7:2] == OFS_VSET2[7:2]) begin
        custom_q.boostVoltageLimit  <= (custom_q.boostVoltageLimit & ~wMask[15:0])
                                     | (wData_q[15:0] & wMask[15:0]);
        custom_q.equaliseVoltage    <= (custom_q.equaliseVoltage & ~wMask[31:16])
                                     | (wData_q[31:16] & wMask[31:16]);
      end else if (wAddr_q[7:2] == OFS_VSET3[7:2]) begin
        custom_q.hysteresisBand     <= (custom_q.hysteresisBand & ~wMask[15:0])
                                     | (wData_q[15:0] & wMask[15:0]);
        custom_q.boostReturn        <= (custom_q.boostReturn & ~wMask[31:16])
                                     | (wData_q[31:16] & wMask[31:16]);
      end else if (wAddr_q[7:2] == OFS_TSET[7:2]) begin
        if (wStrb_q[0]) custom_q.absorptionDuration <= wData_q[7:0];
        if (wStrb_q[1]) custom_q.equaliseDuration   <= wData_q[15:8];
        if (wStrb_q[2]) custom_q.boostDuration      <= wData_q[23:16];
        if (wStrb_q[3]) custom_q.chargeCurrentLimit <= wData_q[31:24];
      end else if (wStrb_q[0]) begin
        custom_q.nightLight        <= wData_q[0];
        custom_q.lowBattDisconnect <= wData_q[1];
      end
    end
  end

  // status view
  crp_stage_t stage_q;
  logic       chargeGate_q;
  logic       loadLowOff_q;
  logic [7:0] duty_q;
  logic       eqPending_q;

  // read channel: one word per request
  logic [31:0] rdWord;
  logic [1:0]  rdResp;
  always_comb begin
    rdWord = 32'h0000_0000;
    rdResp = RESP_OKAY;
    if (s_axi_araddr[7:2] == OFS_CTRL[7:2]) begin
      rdWord = {24'h00_0000, eqPending_q, pwmSel_q, voltMult_q, progSel_q};
    end else if (s_axi_araddr[7:2] == OFS_LOCK[7:2]) begin
      rdWord = {31'h0000_0000, lockout_q};
    end else if (s_axi_araddr[7:2] >= OFS_VSET1[7:2]
                 && s_axi_araddr[7:2] <= OFS_LOAD[7:2]) begin
      if (customMode) begin
        if (s_axi_araddr[7:2] == OFS_VSET1[7:2]) begin
          rdWord = {custom_q.absorptionSetpoint, custom_q.floatSetpoint};
        end else if (s_axi_araddr[7:2] == OFS_VSET2[7:2]) begin
          rdWord = {custom_q.equaliseVoltage, custom_q.boostVoltageLimit};
        end else if (s_axi_araddr[7:2] == OFS_VSET3[7:2]) begin
          rdWord = {custom_q.boostReturn, custom_q.hysteresisBand};
        end else if (s_axi_araddr[7:2] == OFS_TSET[7:2]) begin
          rdWord = {custom_q.chargeCurrentLimit, custom_q.boostDuration,
                    custom_q.equaliseDuration, custom_q.absorptionDuration};
        end else begin
          rdWord = {30'h0000_0000, custom_q.lowBattDisconnect, custom_q.nightLight};
        end
      end
    end else if (s_axi_araddr[7:2] == OFS_STATUS[7:2]) begin
      rdWord = {16'h0000, duty_q, 2'b00, loadLowOff_q, loadOutputOn,
                chargeSwitchOn, chargeGate_q, stage_q};
    end else if (s_axi_araddr[7:2] == OFS_MEAS[7:2]) begin
      rdWord = {8'h00, chargeCurrent, batteryVoltage};
    end else begin
      rdResp = RESP_DECERR;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdWord;
      s_axi_rresp  <= rdResp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // set point of the present stage
  logic [18:0] setpoint;
  logic [18:0] bandScaled;
  logic [18:0] lowerLevel;
  logic [18:0] battV;
  logic [7:0]  stageDur;
  always_comb begin
    case (stage_q)
      ST_BOOST: begin
        setpoint = scaleV(active.boostVoltageLimit, multEff);
        stageDur = active.boostDuration;
      end
      ST_EQUAL: begin
        setpoint = scaleV(active.equaliseVoltage, multEff);
        stageDur = active.equaliseDuration;
      end
      ST_ABSORB: begin
        setpoint = scaleV(active.absorptionSetpoint, multEff);
        stageDur = active.absorptionDuration;
      end
      default: begin
        setpoint = scaleV(active.floatSetpoint, multEff);
        stageDur = 8'h00;
      end
    endcase
  end
  assign bandScaled = scaleV(active.hysteresisBand, multEff);
  assign lowerLevel = (bandScaled > setpoint) ? 19'h0_0000 : setpoint - bandScaled;
  assign battV      = 19'(batteryVoltage);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chargeGate_q <= 1'b1;
    end else if (battV >= setpoint) begin
      chargeGate_q <= 1'b0;
    end else if (battV <= lowerLevel || pwmSel_q) begin
      chargeGate_q <= 1'b1;
    end
  end

  // one-second tick
  logic [31:0] secDiv_q;
  logic        secTick;
  assign secTick = (secDiv_q == 32'(SEC_CYC - 1));
  always_ff @(posedge core_clk) begin
    if (!rst_n || secTick) begin
      secDiv_q <= 32'h0000_0000;
    end else begin
      secDiv_q <= secDiv_q + 32'h0000_0001;
    end
  end

  // stage timers
  logic [19:0] stageSec_q;
  logic [19:0] eqWallSec_q;
  logic        timeDone;
  logic        eqExpired;
  logic        stageChange;
  crp_stage_t  stageNext;
  assign timeDone  = (stageSec_q >= 20'(stageDur) * 20'(TENTH_HR_SEC));
  assign eqExpired = (eqWallSec_q >= 20'(EQ_LIMIT_SEC));
  assign stageChange = (stageNext != stage_q);

  // stage timer runs only above set point minus band; equalise wall timer runs regardless
  always_ff @(posedge core_clk) begin
    if (!rst_n || stageChange) begin
      stageSec_q  <= 20'h0_0000;
      eqWallSec_q <= 20'h0_0000;
    end else if (secTick) begin
      if (battV > lowerLevel && !timeDone) begin
        stageSec_q <= stageSec_q + 20'h0_0001;
      end
      if (stage_q == ST_EQUAL && !eqExpired) begin
        eqWallSec_q <= eqWallSec_q + 20'h0_0001;
      end
    end
  end

  // stage sequence with return to boost
  always_comb begin
    stageNext = stage_q;
    case (stage_q)
      ST_BOOST: begin
        // wait for the full boost time
        if (timeDone) begin
          stageNext = (eqPending_q && active.equaliseDuration != 8'h00) ? ST_EQUAL
                                                                         : ST_ABSORB;
        end
      end
      ST_EQUAL: begin
        if (timeDone || eqExpired) begin
          stageNext = ST_ABSORB;
        end
      end
      ST_ABSORB: begin
        // wait for the full absorption time
        if (timeDone) begin
          stageNext = ST_FLOAT;
        end
      end
      default: begin
        if (battV < scaleV(active.boostReturn, multEff)) begin
          stageNext = ST_BOOST;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage_q <= ST_BOOST;
    end else begin
      stage_q <= stageNext;
    end
  end

  // equalise request, a new request wins over its own clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      eqPending_q <= 1'b0;
    end else if (doWrite && ctrlOk && wStrb_q[0] && wData_q[CTRL_EQ_BIT]) begin
      eqPending_q <= 1'b1;
    end else if (stage_q == ST_BOOST && stageNext != ST_BOOST) begin
      eqPending_q <= 1'b0;
    end
  end

  // current limit trims the duty cycle
  logic [7:0] pwmCnt_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      duty_q   <= 8'hFF;
      pwmCnt_q <= 8'h00;
    end else begin
      pwmCnt_q <= pwmCnt_q + 8'h01;
      if (pwmCnt_q == 8'hFF) begin
        if (chargeCurrent > active.chargeCurrentLimit && duty_q != 8'h00) begin
          duty_q <= duty_q - 8'h01;
        end else if (chargeCurrent < active.chargeCurrentLimit && duty_q != 8'hFF) begin
          duty_q <= duty_q + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chargeSwitchOn <= 1'b0;
    end else begin
      chargeSwitchOn <= chargeGate_q && (duty_q == 8'hFF || pwmCnt_q < duty_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      loadLowOff_q <= 1'b0;
    end else if (battV < scaleV(PV_LOAD_OFF, multEff)) begin
      loadLowOff_q <= 1'b1;
    end else if (battV > scaleV(PV_LOAD_ON, multEff)) begin
      loadLowOff_q <= 1'b0;
    end
  end

  // load on normally or at night only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      loadOutputOn <= 1'b0;
    end else begin
      loadOutputOn <= (!active.nightLight || nightTime)
                      && !(active.lowBattDisconnect && loadLowOff_q);
    end
  end
endmodule
`default_nettype wire

// *** crp_charge_regulation_monitor.sv ***
// checker for the charge regulation block: bus timing, decode, lockout pulse
// assumes only top-level ports are visible; attached by bind below
`timescale 1ns/1ps
`default_nettype none
module crp_charge_regulation_monitor (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        nvLockoutWrite,
  input wire logic        chargeSwitchOn
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic wrGo;
  // both write halves taken at one edge
  assign wrGo = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wr_latency_a: assert property (wrGo |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after request");
  wr_decode_a: assert property (wrGo && s_axi_awaddr > 8'h23 |-> ##2 s_axi_bresp == 2'h3)
    else $error("unmapped write not decode error");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  rd_decode_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h23
    |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not decode error with zero data");
  nv_pulse_a: assert property (nvLockoutWrite |=> !nvLockoutWrite)
    else $error("lockout store pulse longer than one cycle");
  // main scenarios reached
  wr_seen_c: cover property (wrGo);
  lock_seen_c: cover property (nvLockoutWrite);
  sw_off_c: cover property ($fell(chargeSwitchOn));
endmodule
bind crp_charge_regulation crp_charge_regulation_monitor mon_u (.core_clk, .rst_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .nvLockoutWrite, .chargeSwitchOn);
`default_nettype wire

// *** crp_charge_regulation_tb.sv ***
// self-checking bench for the charge regulation block
// assumes a short second tick so stage timers run out within the test
`timescale 1ns/1ps
`default_nettype none
module crp_charge_regulation_tb;
  import crp_pkg::*;
  logic        core_clk = 0, rst_n = 0, nightTime = 0, nvLockoutIn = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, chargeCurrent = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [15:0] levelReq = 16'h04E2, batteryVoltage;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        nvLockoutWrite, nvLockoutData, chargeSwitchOn, loadOutputOn;
  int          fails = 0, checked = 0;
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  crp_charge_regulation #(.SEC_CYC(4)) dut_u (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .batteryVoltage, .chargeCurrent, .nightTime,
    .nvLockoutIn, .nvLockoutWrite, .nvLockoutData, .chargeSwitchOn, .loadOutputOn);
  crp_battery_model bat_u (.core_clk, .levelReq, .batteryVoltage);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bus write, response code compared
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw;
    @(posedge core_clk);
    pa = 1;
    pw = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge core_clk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      if (!pa) s_axi_awvalid <= 0;
      if (!pw) s_axi_wvalid <= 0;
    end while (pa || pw);
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    cmp(32'(s_axi_bresp), 32'(er));
  endtask
  // bus read, data and response compared
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    cmp(s_axi_rdata, ed);
    cmp(32'(s_axi_rresp), 32'(er));
  endtask
  // settle, then compare charge switch and load terminal
  task automatic outs(input logic [15:0] v, input logic [1:0] e);
    levelReq <= v;
    repeat (8) @(posedge core_clk);
    repeat (16) if ({chargeSwitchOn, loadOutputOn} !== e) @(posedge core_clk);
    cmp(32'({chargeSwitchOn, loadOutputOn}), 32'(e));
  endtask
  task automatic tRegs;
    rd(OFS_CTRL, 32'h0000_0009, 2'h0);
    rd(OFS_VSET1, 32'h0000_0000, 2'h0);
    wr(OFS_VSET1, 32'h1234_5678, 2'h2);
    rd(8'h40, 32'h0000_0000, 2'h3);
    wr(8'h40, 32'h0000_0000, 2'h3);
    wr(OFS_CTRL, 32'h0000_000C, 2'h0);
    rd(OFS_VSET1, {PV_ABSORB, PV_FLOAT}, 2'h0);
    rd(OFS_VSET2, {PV_EQ_SEAL, PV_BOOST_SEAL}, 2'h0);
    rd(OFS_TSET, {PC_LIMIT, PT_BOOST, PT_EQ_SEAL, PT_ABSORB}, 2'h0);
    wr(OFS_VSET3, {PV_RETURN, 16'h0030}, 2'h0);
    rd(OFS_VSET3, {PV_RETURN, 16'h0030}, 2'h0);
    wr(OFS_CTRL, 32'h0000_0009, 2'h0);
    $display("test registers done");
  endtask
  task automatic tLock;
    wr(OFS_LOCK, 32'h0000_0001, 2'h0);
    cmp(32'(nvLockoutData), 32'h0000_0001);
    cmp(32'(nvLockoutWrite), 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_000B, 2'h2);
    rd(OFS_CTRL, 32'h0000_0009, 2'h0);
    wr(OFS_LOCK, 32'h0000_0001, 2'h0);
    rd(OFS_LOCK, 32'h0000_0000, 2'h0);
    nvLockoutIn <= 1;
    rst_n <= 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    rd(OFS_LOCK, 32'h0000_0001, 2'h0);
    wr(OFS_LOCK, 32'h0000_0001, 2'h0);
    $display("test lockout done");
  endtask
  task automatic tHyst;
    outs(16'h058C, 2'h1);
    outs(16'h0565, 2'h1);
    outs(16'h0564, 2'h3);
    wr(OFS_CTRL, 32'h0000_0011, 2'h0);
    outs(16'h058C, 2'h2);
    outs(16'h0B18, 2'h1);
    outs(16'h0AC8, 2'h3);
    wr(OFS_CTRL, 32'h0000_0009, 2'h0);
    $display("test hysteresis done");
  endtask
  task automatic tLoad;
    outs(16'h045F, 2'h2);
    outs(16'h0501, 2'h3);
    wr(OFS_CTRL, 32'h0000_000B, 2'h0);
    outs(16'h0501, 2'h2);
    nightTime <= 1;
    outs(16'h0501, 2'h3);
    outs(16'h045F, 2'h2);
    nightTime <= 0;
    $display("test load done");
  endtask
  task automatic tStage;
    wr(OFS_CTRL, 32'h0000_000C, 2'h0);
    wr(OFS_TSET, {PC_LIMIT, 8'h01, 16'h0000}, 2'h0);
    outs(16'h0570, 2'h3);
    rd(OFS_STATUS, 32'h0000_FF1C, 2'h0);
    repeat (1500) @(posedge core_clk);
    rd(OFS_STATUS, 32'h0000_FF13, 2'h0);
    $display("test stages done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    tRegs;
    tLock;
    tHyst;
    tLoad;
    tStage;
    stop_test;
  end
  // watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    stop_test;
  end
endmodule
`default_nettype wire

// *** crp_pkg.sv ***
// package for the charge regulation preset block: register map, preset values, timing
// assumes a single 25 MHz core clock and voltages in 10 mV units of a 12 V system
//
// How it works
// - program 4 makes every setting adjustable
// - lockout refuses every settings change
// - programs 0-3 enable low-battery disconnect
// - programs 2,3 light load at night
// - programs 0,1 keep load on normally
// - 0,2 flooded values; 1,3 sealed values
// - presets are fixed, hidden, not editable
// - set points scaled by system voltage/12
// - program 4 exposes all setting groups
// - non-PWM: switch off at set point
// - float recharges below set point minus band
// - band gates boost, equalise, absorption timers
// - absorption timer pauses below set point-band
// - advance only after full timed duration
// - equalise ends after four days anyway
// - lockout kept in non-volatile storage
// - over-current lowers charge duty cycle
package crp_pkg;
  // timing
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned SEC_CYCLES    = CLK_HZ;       // cycles per second
  localparam int unsigned TENTH_HR_SEC  = 360;          // seconds per 0.1 h
  localparam int unsigned EQ_LIMIT_DAYS = 4;
  localparam int unsigned EQ_LIMIT_SEC  = EQ_LIMIT_DAYS * 24 * 3600;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LOCK   = 8'h04;
  localparam logic [7:0] OFS_VSET1  = 8'h08;
  localparam logic [7:0] OFS_VSET2  = 8'h0C;
  localparam logic [7:0] OFS_VSET3  = 8'h10;
  localparam logic [7:0] OFS_TSET   = 8'h14;
  localparam logic [7:0] OFS_LOAD   = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_MEAS   = 8'h20;
  // control field positions
  localparam int unsigned CTRL_PROG_LSB = 0;   // 3 bits
  localparam int unsigned CTRL_MULT_LSB = 3;   // 3 bits, system volts / 12
  localparam int unsigned CTRL_PWM_BIT  = 6;
  localparam int unsigned CTRL_EQ_BIT   = 7;   // write 1 requests equalise
  localparam logic [2:0]  PROG_CUSTOM   = 3'h4;
  localparam logic [2:0]  RST_PROG      = 3'h1;
  localparam logic [2:0]  RST_MULT      = 3'h1;
  localparam logic        RST_PWM       = 1'b0;
  // preset values, 10 mV units for a 12 V system, 0.1 h, 0.1 A
  localparam logic [15:0] PV_BOOST_FLOOD = 16'h05DC;  // 15.0 V
  localparam logic [15:0] PV_BOOST_SEAL  = 16'h058C;  // 14.2 V
  localparam logic [15:0] PV_EQ_FLOOD    = 16'h0640;  // 16.0 V
  localparam logic [15:0] PV_EQ_SEAL     = 16'h0578;  // 14.0 V
  localparam logic [7:0]  PT_EQ_FLOOD    = 8'h0A;     // 1.0 h
  localparam logic [7:0]  PT_EQ_SEAL     = 8'h00;
  localparam logic [15:0] PV_ABSORB      = 16'h0578;  // 14.0 V
  localparam logic [7:0]  PT_ABSORB      = 8'h14;     // 2.0 h
  localparam logic [15:0] PV_FLOAT       = 16'h0564;  // 13.8 V
  localparam logic [15:0] PV_BAND        = 16'h0028;  // 0.4 V
  localparam logic [15:0] PV_RETURN      = 16'h04CE;  // 12.3 V
  localparam logic [7:0]  PC_LIMIT       = 8'hC8;     // 20 A
  localparam logic [7:0]  PT_BOOST       = 8'h0A;     // 1.0 h
  localparam logic [15:0] PV_LOAD_OFF    = 16'h0460;  // 11.2 V
  localparam logic [15:0] PV_LOAD_ON     = 16'h0500;  // 12.8 V
  // charging stages
  typedef enum logic [1:0] {ST_BOOST, ST_EQUAL, ST_ABSORB, ST_FLOAT} crp_stage_t;
  // one full regulation set
  typedef struct packed {
    logic [15:0] floatSetpoint;
    logic [15:0] absorptionSetpoint;
    logic [15:0] boostVoltageLimit;
    logic [15:0] equaliseVoltage;
    logic [15:0] hysteresisBand;
    logic [15:0] boostReturn;
    logic [7:0]  absorptionDuration;
    logic [7:0]  equaliseDuration;
    logic [7:0]  boostDuration;
    logic [7:0]  chargeCurrentLimit;
    logic        nightLight;
    logic        lowBattDisconnect;
  } crp_settings_t;
endpackage
